/* File: design/odtc_core.sv */
// On-die termination control: latency timing and termination selection
`timescale 1ns/1ps
module odtc_core
    import odtc_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input wire logic sys_clk, // System clock, 20 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic ck_pin, // Link clock from the controller
    input wire logic odt_pin, // ODT request from the controller
    input wire logic wr_cmd_pin, // Write command decoded on the link
    input wire logic rd_cmd_pin, // Read command decoded on the link
    input wire logic a12_pin, // Burst select with the command, high for BL8
    input wire logic dll_enable, // DLL enable bit of the mode registers
    input wire logic dll_locked, // DLL lock status
    input wire logic self_refresh, // Device is in self refresh
    input wire logic preamble_2t, // 2tCK write/read preamble selected
    input wire logic crc_enable, // Write CRC enabled
    input wire logic [1:0] bl_mode, // Burst length mode, odtc_bl_t encoding
    input wire logic [4:0] cwl, // CAS write latency
    input wire logic [5:0] cl, // CAS latency
    input wire logic [4:0] al, // Additive latency
    input wire logic [2:0] pl, // Parity latency
    input wire logic [2:0] rtt_nom_code, // Nominal termination field
    input wire logic [2:0] rtt_wr_code, // Write termination field
    input wire logic [2:0] rtt_park_code, // Parking termination field
    input wire logic hold_err_clr, // Clears the ODT hold error flag
    output logic [1:0] term_state, // Selected termination, odtc_term_t
    output logic [2:0] term_code, // Resistance code of the selection
    output logic async_mode, // Asynchronous ODT timing in use
    output logic odt_ignored, // ODT pin is being ignored
    output logic dyn_odt_on, // Dynamic ODT enabled
    output logic hold_err // Sticky: ODT released before hold time
);
    // ==========================================================
    // Parameter check
    // ==========================================================
    if (DEPTH < 16 || DEPTH > (1 << LAT_W)) begin : g_chk
        $error("odtc_core: DEPTH must be 16 to 2**LAT_W");
    end

    // ==========================================================
    // Pin synchronisers and link clock edge
    // ==========================================================
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;
    logic ck_d_reg;
    logic tick;

    assign pins_raw = {a12_pin, rd_cmd_pin, wr_cmd_pin, odt_pin, ck_pin};

    odtc_sync #(
        .WIDTH(PIN_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(pins_raw),
        .q(pins_s)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ck_d_reg <= 1'b0;
        end else begin
            ck_d_reg <= pins_s[PIN_CK];
        end
    end

    // Every link cycle count below advances on this rising edge only
    assign tick = pins_s[PIN_CK] & ~ck_d_reg;

    // ==========================================================
    // Mode decode
    // ==========================================================
    logic sync_mode;
    logic nom_en;
    logic park_en;
    logic odt_en;
    logic dyn_en;

    // Synchronous whenever the DLL is enabled and locked; CKE and power-down
    // states do not change the timing.
    assign sync_mode = dll_enable & dll_locked;
    // An enabled but unlocked DLL is treated like a disabled one
    assign async_mode = ~sync_mode;
    assign nom_en = (rtt_nom_code != RTT_DISABLED);
    assign park_en = (rtt_park_code != RTT_DISABLED);
    assign odt_en = nom_en & ~self_refresh;
    assign odt_ignored = ~odt_en;
    // A zero write field clears both enable bits
    assign dyn_en = (rtt_wr_code[DYN_A9_BIT] | rtt_wr_code[DYN_A10_BIT])
        & sync_mode;
    assign dyn_odt_on = dyn_en;

    // ==========================================================
    // Latency arithmetic
    // ==========================================================
    logic [LAT_W-1:0] wl;
    logic [LAT_W-1:0] rl;
    logic [LAT_W-1:0] pre_x;
    logic [LAT_W-1:0] dodtl;
    logic [LAT_W-1:0] rodtloff;
    logic [LAT_W-1:0] rd_len4;
    logic [LAT_W-1:0] rd_len8;
    logic [LAT_W-1:0] rodtlon4;
    logic [LAT_W-1:0] rodtlon8;
    logic [LAT_W-1:0] cnw;
    logic [LAT_W-1:0] cwn4_add;
    logic [LAT_W-1:0] cwn8_add;
    logic [LAT_W-1:0] cwn4;
    logic [LAT_W-1:0] cwn8;
    logic [LAT_W-1:0] odth_need;

    // Additive and parity latency are folded into both bases
    assign wl = LAT_W'({2'h0, cwl}) + LAT_W'({2'h0, al}) + LAT_W'({4'h0, pl});
    assign rl = LAT_W'({1'h0, cl}) + LAT_W'({2'h0, al}) + LAT_W'({4'h0, pl});
    assign pre_x = preamble_2t ? PRE_X_2T : PRE_X_1T;

    // Latencies clamp at zero for settings below the preamble offset
    assign dodtl = (wl > pre_x) ? (wl - pre_x) : '0;
    assign rodtloff = (rl > pre_x) ? (rl - pre_x) : '0;
    assign rd_len4 = preamble_2t ? RD_ON4_2T : RD_ON4_1T;
    assign rd_len8 = preamble_2t ? RD_ON8_2T : RD_ON8_1T;
    assign rodtlon4 = rodtloff + rd_len4;
    assign rodtlon8 = rodtloff + rd_len8;

    assign cnw = dodtl;
    assign cwn4_add = preamble_2t ? (crc_enable ? CWN4_2T_CRC : CWN4_2T_NOCRC)
        : (crc_enable ? CWN4_1T_CRC : CWN4_1T_NOCRC);
    assign cwn8_add = preamble_2t ? (crc_enable ? CWN8_2T_CRC : CWN8_2T_NOCRC)
        : (crc_enable ? CWN8_1T_CRC : CWN8_1T_NOCRC);
    assign cwn4 = cnw + cwn4_add;
    assign cwn8 = cnw + cwn8_add;

    // ==========================================================
    // Command capture on the link clock edge
    // ==========================================================
    logic is_bc4;
    logic wr_now;
    logic rd_now;
    logic odt_now;

    // On-the-fly mode takes the burst from A12 with the command
    assign is_bc4 = (bl_mode == ODTC_BC4_FIXED)
        | ((bl_mode == ODTC_BL_OTF) & ~pins_s[PIN_A12]);
    assign wr_now = pins_s[PIN_WR];
    assign rd_now = pins_s[PIN_RD];
    assign odt_now = pins_s[PIN_ODT] & odt_en;

    // ==========================================================
    // Event histories, one bit per link cycle
    // ==========================================================
    logic [DEPTH-1:0] odt_hist_reg;
    logic [DEPTH-1:0] wr4_hist_reg;
    logic [DEPTH-1:0] wr8_hist_reg;
    logic [DEPTH-1:0] rd4_hist_reg;
    logic [DEPTH-1:0] rd8_hist_reg;

    // Bit 0 holds what the latest edge registered; a latency of N
    // reads bit N, which it reaches at the N-th following edge.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            odt_hist_reg <= '0;
            wr4_hist_reg <= '0;
            wr8_hist_reg <= '0;
            rd4_hist_reg <= '0;
            rd8_hist_reg <= '0;
        end else if (tick) begin
            odt_hist_reg <= {odt_hist_reg[DEPTH-2:0], odt_now};
            wr4_hist_reg <= {wr4_hist_reg[DEPTH-2:0], wr_now & is_bc4};
            wr8_hist_reg <= {wr8_hist_reg[DEPTH-2:0], wr_now & ~is_bc4};
            rd4_hist_reg <= {rd4_hist_reg[DEPTH-2:0], rd_now & is_bc4};
            rd8_hist_reg <= {rd8_hist_reg[DEPTH-2:0], rd_now & ~is_bc4};
        end
    end

    // ==========================================================
    // Termination windows
    // ==========================================================
    logic wr4_win;
    logic wr8_win;
    logic rd4_win;
    logic rd8_win;

    odtc_window #(
        .DEPTH(DEPTH),
        .LAT_W(LAT_W)
    ) u_wr4 (
        .hist(wr4_hist_reg),
        .lo(cnw),
        .hi(cwn4),
        .active(wr4_win)
    );

    odtc_window #(
        .DEPTH(DEPTH),
        .LAT_W(LAT_W)
    ) u_wr8 (
        .hist(wr8_hist_reg),
        .lo(cnw),
        .hi(cwn8),
        .active(wr8_win)
    );

    odtc_window #(
        .DEPTH(DEPTH),
        .LAT_W(LAT_W)
    ) u_rd4 (
        .hist(rd4_hist_reg),
        .lo(rodtloff),
        .hi(rodtlon4),
        .active(rd4_win)
    );

    odtc_window #(
        .DEPTH(DEPTH),
        .LAT_W(LAT_W)
    ) u_rd8 (
        .hist(rd8_hist_reg),
        .lo(rodtloff),
        .hi(rodtlon8),
        .active(rd8_win)
    );

    // ==========================================================
    // Termination selection
    // ==========================================================
    logic rd_dis;
    logic wr_sel;
    logic nom_sel;
    logic nom_sync;
    logic nom_async;
    odtc_term_t term_next;
    logic [2:0] code_next;
    odtc_term_t term_reg;
    logic [2:0] code_reg;

    // Driver and termination never overlap during read data
    assign rd_dis = rd4_win | rd8_win;
    assign wr_sel = dyn_en & (wr4_win | wr8_win);
    // Same tap serves on and off, since both latencies are equal
    assign nom_sync = odt_hist_reg[dodtl[$clog2(DEPTH)-1:0]]
        & ({1'b0, dodtl} < (LAT_W + 1)'(DEPTH));
    // Without the DLL the pin acts with no latency
    assign nom_async = odt_now;
    // History taken before the nominal field was cleared must not select it
    assign nom_sel = nom_en & (sync_mode ? nom_sync : nom_async);

    always_comb begin
        term_next = ODTC_HIZ;
        code_next = RTT_DISABLED;
        if (self_refresh) begin
            term_next = ODTC_HIZ;
            code_next = RTT_DISABLED;
        end else if (rd_dis) begin
            term_next = ODTC_HIZ;
            code_next = RTT_DISABLED;
        end else if (wr_sel) begin
            term_next = ODTC_WR;
            code_next = rtt_wr_code;
        end else if (nom_sel) begin
            term_next = ODTC_NOM;
            code_next = rtt_nom_code;
        end else if (park_en) begin
            term_next = ODTC_PARK;
            code_next = rtt_park_code;
        end
    end

    // Sync reset may look at the parking field directly
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            term_reg <= park_en ? ODTC_PARK : ODTC_HIZ;
            code_reg <= park_en ? rtt_park_code : RTT_DISABLED;
        end else begin
            term_reg <= term_next;
            code_reg <= code_next;
        end
    end

    assign term_state = term_reg;
    assign term_code = code_reg;

    // ==========================================================
    // ODT hold check on the controller
    // ==========================================================
    // The controller owns the hold time; this only flags a short
    // pulse so software can see it. The unspecified CRC extension
    // is not checked, so the flag is a lower bound.
    logic odt_prev_reg;
    logic [LAT_W-1:0] hold_cnt_reg;
    logic [LAT_W-1:0] hold_cnt_next;
    logic hold_err_reg;
    logic hold_short;

    assign odth_need = is_bc4 ? (preamble_2t ? ODTH4_2T : ODTH4_1T)
        : (preamble_2t ? ODTH8_2T : ODTH8_1T);
    // Count restarts at first high or at a write, and saturates
    assign hold_cnt_next = (~odt_prev_reg | wr_now) ? '0
        : ((&hold_cnt_reg) ? hold_cnt_reg : hold_cnt_reg + 1'b1);
    assign hold_short = tick & ~odt_now & odt_prev_reg
        & (hold_cnt_reg < (odth_need - 1'b1));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            odt_prev_reg <= 1'b0;
            hold_cnt_reg <= '0;
        end else if (tick) begin
            odt_prev_reg <= odt_now;
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    // A new violation beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_err_reg <= 1'b0;
        end else if (hold_short) begin
            hold_err_reg <= 1'b1;
        end else if (hold_err_clr) begin
            hold_err_reg <= 1'b0;
        end
    end

    assign hold_err = hold_err_reg;
endmodule

/* File: design/odtc_pkg.sv */
// Shared constants and types for the on-die termination control block
package odtc_pkg;
    // Width of every latency figure, in link clock cycles
    localparam int LAT_W = 7;
    // Preamble offsets subtracted from write and read latency
    localparam logic [LAT_W-1:0] PRE_X_1T = 7'h02;
    localparam logic [LAT_W-1:0] PRE_X_2T = 7'h03;
    // Read termination-off window length after the read turn-off latency
    localparam logic [LAT_W-1:0] RD_ON4_1T = 7'h04;
    localparam logic [LAT_W-1:0] RD_ON4_2T = 7'h05;
    localparam logic [LAT_W-1:0] RD_ON8_1T = 7'h06;
    localparam logic [LAT_W-1:0] RD_ON8_2T = 7'h07;
    // Write termination window length after the change-to-write latency
    localparam logic [LAT_W-1:0] CWN4_1T_NOCRC = 7'h04;
    localparam logic [LAT_W-1:0] CWN4_1T_CRC = 7'h07;
    localparam logic [LAT_W-1:0] CWN4_2T_NOCRC = 7'h05;
    localparam logic [LAT_W-1:0] CWN4_2T_CRC = 7'h08;
    localparam logic [LAT_W-1:0] CWN8_1T_NOCRC = 7'h06;
    localparam logic [LAT_W-1:0] CWN8_1T_CRC = 7'h07;
    localparam logic [LAT_W-1:0] CWN8_2T_NOCRC = 7'h07;
    localparam logic [LAT_W-1:0] CWN8_2T_CRC = 7'h08;
    // Least ODT assertion time expected from the controller
    localparam logic [LAT_W-1:0] ODTH4_1T = 7'h04;
    localparam logic [LAT_W-1:0] ODTH4_2T = 7'h05;
    localparam logic [LAT_W-1:0] ODTH8_1T = 7'h06;
    localparam logic [LAT_W-1:0] ODTH8_2T = 7'h07;
    // Write termination field bits that enable dynamic switching
    localparam int DYN_A9_BIT = 0;
    localparam int DYN_A10_BIT = 1;
    // Resistance code meaning termination disabled
    localparam logic [2:0] RTT_DISABLED = 3'h0;
    // Positions of the pins in the synchroniser vector
    localparam int PIN_CK = 0;
    localparam int PIN_ODT = 1;
    localparam int PIN_WR = 2;
    localparam int PIN_RD = 3;
    localparam int PIN_A12 = 4;
    localparam int PIN_W = 5;

    typedef enum logic [1:0] {
        ODTC_HIZ = 2'b00,
        ODTC_PARK = 2'b01,
        ODTC_NOM = 2'b10,
        ODTC_WR = 2'b11
    } odtc_term_t;

    typedef enum logic [1:0] {
        ODTC_BL8_FIXED = 2'b00,
        ODTC_BL_OTF = 2'b01,
        ODTC_BC4_FIXED = 2'b10
    } odtc_bl_t;
endpackage

/* File: design/odtc_sync.sv */
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module odtc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [WIDTH-1:0] d, // Asynchronous pin levels
    output logic [WIDTH-1:0] q // Synchronised levels
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    if (WIDTH < 1) begin : g_chk
        $error("odtc_sync: WIDTH must be at least 1");
    end

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule

/* File: design/odtc_window.sv */
// Finds whether any event in a history lies inside a latency window
`timescale 1ns/1ps
module odtc_window #(
    parameter int DEPTH = 64,
    parameter int LAT_W = 7
) (
    input wire logic [DEPTH-1:0] hist, // Bit i set: event seen i link cycles ago
    input wire logic [LAT_W-1:0] lo, // First cycle of the window, inclusive
    input wire logic [LAT_W-1:0] hi, // End of the window, exclusive
    output logic active // Window holds an event
);
    logic [DEPTH-1:0] hit;

    if (DEPTH < 2 || DEPTH > (1 << LAT_W)) begin : g_chk
        $error("odtc_window: DEPTH out of range for LAT_W");
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_tap
        localparam logic [LAT_W-1:0] IDX = LAT_W'(i);
        assign hit[i] = hist[i] && (IDX >= lo) && (IDX < hi);
    end

    assign active = |hit;
endmodule

/* File: test/odtc_core_properties.sv */
// Port checker for the termination control block
`timescale 1ns/1ps
module odtc_core_properties
    import odtc_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic rst, // Reset
    input wire logic dll_enable, // DLL on
    input wire logic dll_locked, // DLL lock
    input wire logic self_refresh, // Self refresh
    input wire logic [2:0] rtt_nom_code, // Nominal field
    input wire logic [2:0] rtt_wr_code, // Write field
    input wire logic [2:0] rtt_park_code, // Parking field
    input wire logic hold_err_clr, // Flag clear
    input wire logic [1:0] term_state, // Selection
    input wire logic [2:0] term_code, // Selected code
    input wire logic async_mode, // Async timing
    input wire logic odt_ignored, // Pin ignored
    input wire logic dyn_odt_on, // Dynamic ODT
    input wire logic hold_err // Hold flag
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ====
    // Decodes
    a_async_decode: assert property (async_mode == !(dll_enable && dll_locked))
        else $error("async decode wrong");
    a_ignore_decode: assert property (
        odt_ignored == (rtt_nom_code == RTT_DISABLED || self_refresh))
        else $error("ignore decode wrong");
    a_dyn_decode: assert property (
        dyn_odt_on == ((rtt_wr_code[0] || rtt_wr_code[1]) && !async_mode))
        else $error("dynamic decode wrong");
    // ====
    // Selection
    // The code follows last cycle's fields since the selection is registered
    a_code_source: assert property (term_code == (
        term_state == ODTC_HIZ ? 3'h0 : term_state == ODTC_PARK ? $past(rtt_park_code) :
        term_state == ODTC_NOM ? $past(rtt_nom_code) : $past(rtt_wr_code)))
        else $error("code does not match selection");
    a_reset_park: assert property ($past(rst) |-> !hold_err &&
        term_state == (($past(rtt_park_code) != 3'h0) ? ODTC_PARK : ODTC_HIZ))
        else $error("reset selection wrong");
    a_refresh_hiz: assert property (self_refresh |=> term_state == ODTC_HIZ)
        else $error("self refresh not high impedance");
    a_wr_needs_dyn: assert property (term_state == ODTC_WR |-> $past(dyn_odt_on))
        else $error("write termination without dynamic ODT");
    a_ignored_nom: assert property (odt_ignored [*2] |-> term_state != ODTC_NOM)
        else $error("nominal while pin ignored");
    a_hold_sticky: assert property (hold_err && !hold_err_clr |=> hold_err)
        else $error("hold flag dropped without clear");
    c_write: cover property (term_state == ODTC_WR);
    c_read: cover property (term_state == ODTC_HIZ && !self_refresh);
    c_hold: cover property ($rose(hold_err));
endmodule

bind odtc_core odtc_core_properties u_props (.sys_clk(sys_clk), .rst(rst),
    .dll_enable(dll_enable), .dll_locked(dll_locked), .self_refresh(self_refresh),
    .rtt_nom_code(rtt_nom_code), .rtt_wr_code(rtt_wr_code), .rtt_park_code(rtt_park_code),
    .hold_err_clr(hold_err_clr), .term_state(term_state), .term_code(term_code),
    .async_mode(async_mode), .odt_ignored(odt_ignored), .dyn_odt_on(dyn_odt_on),
    .hold_err(hold_err));

/* File: test/odtc_ctrl_model.sv */
// Behavioural memory controller driving the link pins
`timescale 1ns/1ps
module odtc_ctrl_model (
    input wire logic run, // Link clock runs while high
    input wire logic odt_req, // ODT level for next cycle
    input wire logic wr_req, // Write next cycle
    input wire logic rd_req, // Read next cycle
    input wire logic bl8_req, // Burst select
    output logic ck_pin, // Link clock
    output logic odt_pin, // ODT
    output logic wr_cmd_pin, // Write command
    output logic rd_cmd_pin, // Read command
    output logic a12_pin // Burst select pin
);
    // ====
    // Link clock, off phase from the system clock and still while idle
    initial begin
        ck_pin = 1'b0;
        odt_pin = 1'b0;
        wr_cmd_pin = 1'b0;
        rd_cmd_pin = 1'b0;
        a12_pin = 1'b0;
        #37;
        forever begin
            wait (run);
            #200 ck_pin = 1'b1;
            #200 ck_pin = 1'b0;
        end
    end
    // ====
    // Pins move at the falling edge so they stand still around sampling
    always @(negedge ck_pin) begin
        odt_pin <= odt_req;
        wr_cmd_pin <= wr_req;
        rd_cmd_pin <= rd_req;
        // Burst select means nothing without a command, so it keeps changing
        a12_pin <= (wr_req || rd_req) ? bl8_req : ~a12_pin;
    end
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the termination control block
`timescale 1ns/1ps
module testbench
    import odtc_pkg::*;
;
    logic sys_clk = 1'b0, rst = 1'b1, run = 1'b0, hold_err_clr = 1'b0;
    logic odt_q = 1'b0, wr_q = 1'b0, rd_q = 1'b0, bl8_q = 1'b0;
    logic dll_enable = 1'b1, dll_locked = 1'b1, self_refresh = 1'b0;
    logic preamble_2t = 1'b0, crc_enable = 1'b0;
    logic [1:0] bl_mode = 2'h1;
    logic [4:0] cwl = 5'h09, al = 5'h00;
    logic [5:0] cl = 6'h0b;
    logic [2:0] pl = 3'h0, nom = 3'h2, wrc = 3'h1, park = 3'h5;
    logic ck_pin, odt_pin, wr_cmd_pin, rd_cmd_pin, a12_pin;
    logic async_mode, odt_ignored, dyn_odt_on, hold_err;
    logic [1:0] term_state;
    logic [2:0] term_code;
    int lk = 0, e = 0, mismatches = 0, compares = 0;

    odtc_ctrl_model u_ctrl (.run(run), .odt_req(odt_q), .wr_req(wr_q), .rd_req(rd_q),
        .bl8_req(bl8_q), .ck_pin(ck_pin), .odt_pin(odt_pin), .wr_cmd_pin(wr_cmd_pin),
        .rd_cmd_pin(rd_cmd_pin), .a12_pin(a12_pin));
    odtc_core #(.DEPTH(64)) u_dut (.sys_clk(sys_clk), .rst(rst), .ck_pin(ck_pin),
        .odt_pin(odt_pin), .wr_cmd_pin(wr_cmd_pin), .rd_cmd_pin(rd_cmd_pin),
        .a12_pin(a12_pin), .dll_enable(dll_enable), .dll_locked(dll_locked),
        .self_refresh(self_refresh), .preamble_2t(preamble_2t), .crc_enable(crc_enable),
        .bl_mode(bl_mode), .cwl(cwl), .cl(cl), .al(al), .pl(pl), .rtt_nom_code(nom),
        .rtt_wr_code(wrc), .rtt_park_code(park), .hold_err_clr(hold_err_clr),
        .term_state(term_state), .term_code(term_code), .async_mode(async_mode),
        .odt_ignored(odt_ignored), .dyn_odt_on(dyn_odt_on), .hold_err(hold_err));

    // ====
    // Clock and link edge count
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge ck_pin) lk <= lk + 1;

    // ====
    // Tasks
    task automatic close_out();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic chk_term(input odtc_term_t st);
        logic [2:0] cd;
        cd = (st == ODTC_HIZ) ? 3'h0 : (st == ODTC_PARK) ? park : (st == ODTC_NOM) ? nom : wrc;
        compares++;
        if (term_state !== st || term_code !== cd) begin
            mismatches++;
            $display("mismatch at %0t: got %h/%h want %h/%h", $time, term_state, term_code,
                st, cd);
        end
    endtask
    // Returns just after the first system edge that follows link edge t
    task automatic wait_lk(input int t);
        for (int i = 0; i < 2000 && lk < t; i++) @(posedge sys_clk);
        if (lk < t) begin
            mismatches++;
            $display("mismatch at %0t: link edge timeout", $time);
            close_out();
        end
        #1;
    endtask
    // Request for the next link cycle; e is the edge that registers it
    task automatic go(input logic o, input logic w, input logic r, input logic b);
        wait_lk(lk + 1);
        odt_q = o;
        wr_q = w;
        rd_q = r;
        bl8_q = b;
        e = lk + 1;
    endtask
    task automatic end_cmd();
        wait_lk(lk + 1);
        wr_q = 1'b0;
        rd_q = 1'b0;
    endtask
    // Sampled well after the tick and well before the next link edge
    task automatic probe(input int t, input odtc_term_t st);
        wait_lk(t);
        repeat (5) @(posedge sys_clk);
        #1 chk_term(st);
    endtask
    task automatic win(input int t, input odtc_term_t a, input odtc_term_t b);
        probe(t - 1, a);
        probe(t, b);
    endtask

    // ====
    // Sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        #1 rst = 1'b0;
        run = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk_term(ODTC_PARK);
        chk_bit(async_mode, 1'b0, "sync mode");
        go(1, 0, 0, 1);
        win(e + 7, ODTC_PARK, ODTC_NOM);
        go(0, 0, 0, 1);
        win(e + 7, ODTC_NOM, ODTC_PARK);
        chk_bit(hold_err, 1'b0, "hold flag");
        go(1, 1, 0, 1);
        end_cmd();
        win(e + 7, ODTC_PARK, ODTC_WR);
        win(e + 13, ODTC_WR, ODTC_NOM);
        go(1, 0, 1, 1);
        end_cmd();
        win(e + 9, ODTC_NOM, ODTC_HIZ);
        win(e + 15, ODTC_HIZ, ODTC_NOM);
        go(0, 0, 0, 1);
        win(e + 7, ODTC_NOM, ODTC_PARK);
        preamble_2t = 1'b1;
        crc_enable = 1'b1;
        bl_mode = 2'h2;
        al = 5'h02;
        pl = 3'h1;
        go(1, 1, 0, 0);
        end_cmd();
        win(e + 9, ODTC_PARK, ODTC_WR);
        win(e + 17, ODTC_WR, ODTC_NOM);
        go(1, 0, 1, 0);
        end_cmd();
        win(e + 11, ODTC_NOM, ODTC_HIZ);
        win(e + 16, ODTC_HIZ, ODTC_NOM);
        go(0, 0, 0, 0);
        win(e + 9, ODTC_NOM, ODTC_PARK);
        chk_bit(hold_err, 1'b0, "hold flag 2t");
        preamble_2t = 1'b0;
        crc_enable = 1'b0;
        bl_mode = 2'h0;
        al = 5'h00;
        pl = 3'h0;
        go(1, 0, 0, 1);
        go(0, 0, 0, 1);
        probe(e + 9, ODTC_PARK);
        chk_bit(hold_err, 1'b1, "short hold");
        hold_err_clr = 1'b1;
        @(posedge sys_clk);
        #1 hold_err_clr = 1'b0;
        chk_bit(hold_err, 1'b0, "hold clear");
        for (int c = 0; c < 8; c++) begin
            @(posedge sys_clk);
            #1 wrc = c[2:0];
            #1 chk_bit(dyn_odt_on, c[0] | c[1], "dynamic enable");
        end
        wrc = 3'h4;
        go(0, 1, 0, 1);
        end_cmd();
        probe(e + 7, ODTC_PARK);
        nom = 3'h0;
        #1 chk_bit(odt_ignored, 1'b1, "ignore");
        go(1, 0, 0, 1);
        probe(e + 8, ODTC_PARK);
        go(0, 0, 0, 1);
        self_refresh = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk_term(ODTC_HIZ);
        self_refresh = 1'b0;
        nom = 3'h2;
        wrc = 3'h1;
        dll_locked = 1'b0;
        #1 chk_bit(async_mode, 1'b1, "unlocked");
        chk_bit(dyn_odt_on, 1'b0, "dll off dynamic");
        go(1, 1, 0, 1);
        end_cmd();
        probe(e + 1, ODTC_NOM);
        probe(e + 7, ODTC_NOM);
        close_out();
    end
endmodule
